/* inc/co2_link_if.sv */
`timescale 1ns/100ps
interface co2_link_if;
    import co2_pkg::*;
    // Compensation selection
    logic [3:0] en;
    logic tsrc;
    logic [15:0] tsens, tset, pset, oset, hset;
    logic [15:0] t, p, o, h;
    // Analog shaping
    rng_e rng;
    logic [15:0] meas, lo, hi, clip_pm, err_pm, code;
    logic over_clip, over_err;
    modport sel_m (input en, tsrc, tsens, tset, pset, oset, hset, output t, p, o, h);
    modport shp_m (input rng, meas, lo, hi, clip_pm, err_pm, output code, over_clip, over_err);
endinterface : co2_link_if

/* inc/co2_pkg.sv */
// How it works
// - Temperature, pressure, oxygen and humidity compensation each have their own enable.
// - Temperature comes from the on-board sensor or a fixed setpoint, per configuration.
// - Temperature compensation off uses +25 degrees C.
// - Pressure compensation uses only the setpoint written by the host.
// - Pressure compensation off uses 1013 hPa.
// - Oxygen and humidity use host setpoints; factory defaults 21 and 50 percent.
// - Background gas compensation off uses 0 percent for oxygen and humidity.
// - A new setpoint written at any time applies to following measurements.
// - Startup completes and measurements appear within 12 seconds of power-on.
// - Analog output shows the error state until the first measurement exists.
// - A filtering factor sets how fast new measurements blend into the output.
// - Past the clipping limit the analog output holds the clipped value.
// - Past the error limit the analog output goes to the error level.
// - Range 0-10 V clips at 1 percent, errors at 10 percent, level 0 V.
// - Range 0-5 V clips at 5 percent, errors at 10 percent, level 0 V.
// - Current ranges clip at 5, error at 10 percent; levels 23 and 2 mA.
// - Coming back, output steps from error to clipped, then to normal tracking.
// - Output never exceeds 10.325 V; the error voltage is limited to it.
// - Clipping and error affect only the analog output, not digital values.
// - Clipping and error limits are changeable by a configuration write.
package co2_pkg;
    // ****
    // Timing
    // ****
    localparam longint CLK_HZ = 100_000_000;
    localparam longint STARTUP_S = 12;
    localparam logic [31:0] STARTUP_CYC = 32'(STARTUP_S * CLK_HZ);
    // ****
    // Register map
    // ****
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_TSET = 8'h04;
    localparam logic [7:0] A_PSET = 8'h08;
    localparam logic [7:0] A_OSET = 8'h0c;
    localparam logic [7:0] A_HSET = 8'h10;
    localparam logic [7:0] A_FILT = 8'h14;
    localparam logic [7:0] A_SCALE = 8'h18;
    localparam logic [7:0] A_OVER = 8'h1c;
    localparam logic [7:0] A_ERRLVL = 8'h20;
    localparam logic [7:0] A_STAT = 8'h24;
    localparam logic [7:0] A_MEAS = 8'h28;
    localparam logic [7:0] A_AOUT = 8'h2c;
    // Control fields
    localparam int C_TEN = 0;
    localparam int C_PEN = 1;
    localparam int C_OEN = 2;
    localparam int C_HEN = 3;
    localparam int C_TSRC = 4;
    localparam int C_RNG = 5;
    localparam int C_AMODE = 7;
    localparam logic [7:0] CTRL_RST = 8'h9f;
    // ****
    // Values: 0.01 C, 0.1 hPa, 0.01 %, ppm, mV or uA, per mille
    // ****
    localparam logic [15:0] TEMP_OFF = 16'h09c4;
    localparam logic [15:0] PRESS_OFF = 16'h2792;
    localparam logic [15:0] BG_OFF = 16'h0000;
    localparam logic [15:0] O2_RST = 16'h0834;
    localparam logic [15:0] RH_RST = 16'h1388;
    localparam logic [15:0] LO_RST = 16'h0000;
    localparam logic [15:0] HI_RST = 16'h07d0;
    localparam logic [15:0] OUT_ZERO = 16'h0000;
    localparam logic [15:0] OUT_4MA = 16'h0fa0;
    localparam logic [15:0] OUT_5V = 16'h1388;
    localparam logic [15:0] OUT_10V = 16'h2710;
    localparam logic [15:0] OUT_20MA = 16'h4e20;
    localparam logic [15:0] ERR_20MA = 16'h59d8;
    localparam logic [15:0] ERR_4MA = 16'h07d0;
    localparam logic [15:0] VMAX = 16'h2855;
    localparam logic [15:0] PM_1 = 16'h000a;
    localparam logic [15:0] PM_5 = 16'h0032;
    localparam logic [15:0] PM_10 = 16'h0064;
    localparam logic signed [39:0] PERMIL = 40'sh3e8;
    typedef enum logic [1:0] {RNG_5V = 2'h0, RNG_10V = 2'h1, RNG_20MA = 2'h2, RNG_4MA = 2'h3} rng_e;
    typedef enum logic [1:0] {AO_START = 2'h0, AO_NORM = 2'h1, AO_CLIP = 2'h2, AO_ERR = 2'h3} aos_e;
    // Range decoding
    function automatic logic is_volt(input rng_e r);
        return (r == RNG_5V) || (r == RNG_10V);
    endfunction : is_volt
    function automatic logic [15:0] rng_min(input rng_e r);
        return (r == RNG_4MA) ? OUT_4MA : OUT_ZERO;
    endfunction : rng_min
    function automatic logic [15:0] rng_max(input rng_e r);
        return (r == RNG_5V) ? OUT_5V : (r == RNG_10V) ? OUT_10V : OUT_20MA;
    endfunction : rng_max
    function automatic logic [15:0] def_clip(input rng_e r);
        return (r == RNG_10V) ? PM_1 : PM_5;
    endfunction : def_clip
    function automatic logic [15:0] def_errlvl(input rng_e r);
        return (r == RNG_20MA) ? ERR_20MA : (r == RNG_4MA) ? ERR_4MA : OUT_ZERO;
    endfunction : def_errlvl
endpackage : co2_pkg

/* verification/host_model.sv */
`timescale 1ns/100ps
module host_model
    import co2_pkg::*;
(
    // Clock
    input wire logic pclk,
    // APB master side
    output logic [7:0] paddr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic [31:0] rd_q;
    logic err_q;
    // ****
    // Idle bus at time zero
    // ****
    initial begin
        paddr = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0000_0000;
    end
    // Readings are judged for logic only, never for settled accuracy after warm-up
    // One transfer; request held until pready is seen high at an edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            testbench.n_fail++;
            testbench.wrap_up();
        end
    endtask : xfer
    // Error level the host picks is kept within the output maximum
    function automatic logic [31:0] safe_errlvl(input logic [15:0] v);
        return {16'h0000, (v > VMAX) ? VMAX : v};
    endfunction : safe_errlvl
endmodule : host_model

/* verification/testbench.sv */
`timescale 1ns/100ps
module testbench;
    import co2_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tsens_stb, meas_stb;
    logic dig_valid, aout_err, aout_en, startup_done, startup_late;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] tsens, meas_raw, comp_temp, comp_press, comp_o2, comp_rh, dig_ppm, aout_code;
    int n_fail = 0;
    int cmp_count = 0;
    // ****
    // Design and host
    // ****
    co2_comp_ctrl #(.STARTUP_CYCLES(32'd50)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tsens(tsens), .tsens_stb(tsens_stb), .meas_raw(meas_raw), .meas_stb(meas_stb), .comp_temp(comp_temp),
        .comp_press(comp_press), .comp_o2(comp_o2), .comp_rh(comp_rh), .dig_ppm(dig_ppm), .dig_valid(dig_valid),
        .aout_code(aout_code), .aout_err(aout_err), .aout_en(aout_en), .startup_done(startup_done),
        .startup_late(startup_late));
    host_model h (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // Clock generator
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // ****
    // Shared tasks
    // ****
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Register write, then let the selected values settle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        h.xfer(1'b1, a, d);
        repeat (3) @(posedge pclk);
        #1;
    endtask : wr
    // One raw sample, waiting out the three cycle analog path
    task automatic smp(input logic [15:0] v);
        @(posedge pclk);
        meas_stb <= 1'b1;
        meas_raw <= v;
        @(posedge pclk);
        meas_stb <= 1'b0;
        repeat (4) @(posedge pclk);
        #1;
    endtask : smp
    task automatic aout(input logic [15:0] code, input logic err);
        chk("aout_code", {16'h0, code}, {16'h0, aout_code});
        chk("aout_err", {31'h0, err}, {31'h0, aout_err});
    endtask : aout
    task automatic wrap_up();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up
    // ****
    // Scenarios
    // ****
    task automatic t_startup();
        aout(OUT_ZERO, 1'b1);
        chk("startup_done", 32'h0, {31'h0, startup_done});
        chk("dig_valid", 32'h0, {31'h0, dig_valid});
        smp(16'h03e8);
        chk("startup_done", 32'h1, {31'h0, startup_done});
        chk("startup_late", 32'h0, {31'h0, startup_late});
        chk("dig_valid", 32'h1, {31'h0, dig_valid});
        aout(16'h09c4, 1'b0);
        chk("aout_en", 32'h1, {31'h0, aout_en});
        $display("test startup ended");
    endtask : t_startup
    task automatic t_comp();
        wr(A_CTRL, 32'h80);
        chk("t off", {16'h0, TEMP_OFF}, {16'h0, comp_temp});
        chk("p off", {16'h0, PRESS_OFF}, {16'h0, comp_press});
        chk("o off", {16'h0, BG_OFF}, {16'h0, comp_o2});
        chk("h off", {16'h0, BG_OFF}, {16'h0, comp_rh});
        wr(A_CTRL, 32'h8f);
        wr(A_PSET, 32'h2328);
        chk("t set", 32'h09c4, {16'h0, comp_temp});
        chk("p set", 32'h2328, {16'h0, comp_press});
        chk("o set", {16'h0, O2_RST}, {16'h0, comp_o2});
        chk("h set", {16'h0, RH_RST}, {16'h0, comp_rh});
        h.xfer(1'b0, A_PSET, 32'h0);
        chk("pset read", 32'h2328, h.rd_q);
        wr(A_CTRL, 32'h9f);
        @(posedge pclk);
        tsens <= 16'h0bb8;
        tsens_stb <= 1'b1;
        @(posedge pclk);
        tsens_stb <= 1'b0;
        repeat (3) @(posedge pclk);
        #1;
        chk("t sensor", 32'h0bb8, {16'h0, comp_temp});
        h.xfer(1'b0, 8'h30, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, h.err_q});
        chk("unmapped read", 32'h0, h.rd_q);
        $display("test compensation ended");
    endtask : t_comp
    task automatic t_over5();
        smp(16'h0834);
        aout(16'h1482, 1'b0);
        smp(16'h0866);
        aout(16'h1482, 1'b0);
        smp(16'h08fc);
        aout(OUT_ZERO, 1'b1);
        chk("dig_ppm", 32'h08fc, {16'h0, dig_ppm});
        smp(16'h0866);
        aout(16'h1482, 1'b0);
        smp(16'h03e8);
        aout(16'h09c4, 1'b0);
        $display("test overrange ended");
    endtask : t_over5
    task automatic t_ranges();
        wr(A_CTRL, 32'haf);
        smp(16'h0802);
        aout(16'h2774, 1'b0);
        wr(A_ERRLVL, 32'h2ee0);
        smp(16'h08fc);
        aout(VMAX, 1'b1);
        wr(A_ERRLVL, h.safe_errlvl(16'h1f40));
        aout(16'h1f40, 1'b1);
        wr(A_CTRL, 32'hef);
        smp(16'h03e8);
        aout(16'h2ee0, 1'b0);
        smp(16'h08fc);
        aout(ERR_4MA, 1'b1);
        wr(A_CTRL, 32'hcf);
        smp(16'h08fc);
        aout(ERR_20MA, 1'b1);
        $display("test ranges ended");
    endtask : t_ranges
    task automatic t_limits();
        wr(A_CTRL, 32'h8f);
        wr(A_OVER, 32'h00c8_0064);
        smp(16'h0866);
        aout(16'h14ff, 1'b0);
        smp(16'h08fc);
        aout(16'h157c, 1'b0);
        $display("test limits ended");
    endtask : t_limits
    task automatic t_filter();
        smp(16'h03e8);
        wr(A_FILT, 32'h1);
        smp(16'h07d0);
        chk("filtered", 32'h05dc, {16'h0, dig_ppm});
        $display("test filter ended");
    endtask : t_filter
    // Mid-run reset with no sample afterwards: the late start must be flagged
    task automatic t_late();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        chk("dig_valid", 32'h0, {31'h0, dig_valid});
        chk("comp_temp", {16'h0, TEMP_OFF}, {16'h0, comp_temp});
        aout(OUT_ZERO, 1'b1);
        repeat (60) @(posedge pclk);
        #1;
        chk("startup_late", 32'h1, {31'h0, startup_late});
        h.xfer(1'b0, A_STAT, 32'h0);
        chk("stat", 32'h8, h.rd_q);
        aout(OUT_ZERO, 1'b1);
        $display("test late startup ended");
    endtask : t_late
    // ****
    // Main sequence
    // ****
    initial begin
        presetn = 1'b0;
        tsens = 16'h0000;
        tsens_stb = 1'b0;
        meas_raw = 16'h0000;
        meas_stb = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        t_startup();
        t_comp();
        t_over5();
        t_ranges();
        t_limits();
        t_filter();
        t_late();
        wrap_up();
    end
endmodule : testbench

/* verilog/aout_shaper.sv */
`timescale 1ns/100ps
module aout_shaper
    import co2_pkg::*;
(
    // Shaping group
    co2_link_if.shp_m s
);
    logic signed [39:0] span, d, ext, ex, lin, chi, clo, c;

    // Zero-extend to a signed working width
    function automatic logic signed [39:0] sx(input logic [15:0] v);
        return $signed({24'h000000, v});
    endfunction : sx

    // Linear map, clip window and limit compare
    always_comb begin
        span = sx(s.hi) - sx(s.lo);
        if (span < 40'sh1) begin
            span = 40'sh1;
        end
        ext = sx(rng_max(s.rng)) - sx(rng_min(s.rng));
        d = sx(s.meas) - sx(s.lo);
        ex = (d > span) ? d - span : -d; // Distance outside range, negative inside
        lin = sx(rng_min(s.rng)) + d * ext / span;
        chi = sx(rng_max(s.rng)) + ext * sx(s.clip_pm) / PERMIL;
        clo = sx(rng_min(s.rng)) - ext * sx(s.clip_pm) / PERMIL;
        if (clo < 40'sh0) begin
            clo = 40'sh0;
        end
        c = (lin > chi) ? chi : ((lin < clo) ? clo : lin);
        if (is_volt(s.rng) && c > sx(VMAX)) begin
            c = sx(VMAX);
        end
        s.code = c[15:0];
        s.over_clip = ex * PERMIL > span * sx(s.clip_pm);
        s.over_err = ex * PERMIL > span * sx(s.err_pm);
    end
endmodule : aout_shaper

/* verilog/co2_comp_ctrl.sv */
`timescale 1ns/100ps
module co2_comp_ctrl
    import co2_pkg::*;
#(
    parameter logic [31:0] STARTUP_CYCLES = STARTUP_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Temperature sensor reading
    input wire logic [15:0] tsens,
    input wire logic tsens_stb,
    // Raw concentration from the optical core
    input wire logic [15:0] meas_raw,
    input wire logic meas_stb,
    // Compensation values to the model
    output logic [15:0] comp_temp,
    output logic [15:0] comp_press,
    output logic [15:0] comp_o2,
    output logic [15:0] comp_rh,
    // Digital reading
    output logic [15:0] dig_ppm,
    output logic dig_valid,
    // Analog output
    output logic [15:0] aout_code,
    output logic aout_err,
    output logic aout_en,
    // Status
    output logic startup_done,
    output logic startup_late
);

    // ****
    // Declarations
    // ****
    co2_link_if lk();
    logic [7:0] ctrl_q;
    logic [15:0] tset_q, pset_q, oset_q, hset_q;
    logic [2:0] fsh_q;
    logic [15:0] lo_q, hi_q, clip_q, err_q, errlvl_q;
    logic [15:0] tsens_q;
    logic [15:0] filt_q, filt_d;
    logic first_q, upd_q, st_to_q;
    logic [31:0] st_cnt_q;
    logic [31:0] prdata_q;
    logic [15:0] code_q, ct_q, cp_q, co_q, ch_q;
    logic err_q2;
    logic signed [17:0] fdiff, fstep, fnew;
    aos_e aout_state_q, aout_state_d, tgt;
    rng_e rng, wr_rng;
    logic wr_en;

    // Decode of a mapped register address
    function automatic logic mapped(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= A_AOUT);
    endfunction : mapped

    // ****
    // APB slave
    // ****
    assign wr_en = psel && penable && pwrite && mapped(paddr);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);
    assign prdata = prdata_q;
    assign rng = rng_e'(ctrl_q[C_RNG+1:C_RNG]);
    assign wr_rng = rng_e'(pwdata[C_RNG+1:C_RNG]);

    // Control and setpoint registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
            tset_q <= TEMP_OFF;
            pset_q <= PRESS_OFF;
            oset_q <= O2_RST;
            hset_q <= RH_RST;
            fsh_q <= 3'h0;
            lo_q <= LO_RST;
            hi_q <= HI_RST;
        end else if (wr_en) begin
            case (paddr)
                A_CTRL: ctrl_q <= pwdata[7:0];
                A_TSET: tset_q <= pwdata[15:0];
                A_PSET: pset_q <= pwdata[15:0];
                A_OSET: oset_q <= pwdata[15:0];
                A_HSET: hset_q <= pwdata[15:0];
                A_FILT: fsh_q <= pwdata[2:0];
                A_SCALE: begin
                    lo_q <= pwdata[15:0];
                    hi_q <= pwdata[31:16];
                end
                default: ;
            endcase
        end
    end

    // Overrange limits and error level; a range change reloads defaults
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clip_q <= PM_5;
            err_q <= PM_10;
            errlvl_q <= OUT_ZERO;
        end else if (wr_en && paddr == A_CTRL && wr_rng != rng) begin
            clip_q <= def_clip(wr_rng);
            err_q <= PM_10;
            errlvl_q <= def_errlvl(wr_rng);
        end else if (wr_en && paddr == A_OVER) begin
            clip_q <= pwdata[15:0];
            err_q <= pwdata[31:16];
        end else if (wr_en && paddr == A_ERRLVL) begin
            if (is_volt(rng) && pwdata[15:0] > VMAX) begin
                errlvl_q <= VMAX;
            end else begin
                errlvl_q <= pwdata[15:0];
            end
        end
    end

    // Read data captured in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
        end else if (psel && !penable) begin
            case (paddr)
                A_CTRL: prdata_q <= {24'h0, ctrl_q};
                A_TSET: prdata_q <= {16'h0, tset_q};
                A_PSET: prdata_q <= {16'h0, pset_q};
                A_OSET: prdata_q <= {16'h0, oset_q};
                A_HSET: prdata_q <= {16'h0, hset_q};
                A_FILT: prdata_q <= {29'h0, fsh_q};
                A_SCALE: prdata_q <= {hi_q, lo_q};
                A_OVER: prdata_q <= {err_q, clip_q};
                A_ERRLVL: prdata_q <= {16'h0, errlvl_q};
                A_STAT: prdata_q <= {28'h0, st_to_q, first_q, aout_state_q};
                A_MEAS: prdata_q <= {16'h0, filt_q};
                A_AOUT: prdata_q <= {16'h0, code_q};
                default: prdata_q <= 32'h0;
            endcase
        end
    end

    // ****
    // Compensation selection
    // ****
    assign lk.en = ctrl_q[C_HEN:C_TEN];
    assign lk.tsrc = ctrl_q[C_TSRC];
    assign lk.tsens = tsens_q;
    assign lk.tset = tset_q;
    assign lk.pset = pset_q;
    assign lk.oset = oset_q;
    assign lk.hset = hset_q;

    comp_select u_sel (
        .s(lk.sel_m)
    );

    // Latest on-board temperature
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tsens_q <= TEMP_OFF;
        end else if (tsens_stb) begin
            tsens_q <= tsens;
        end
    end

    // Selected values registered towards the model
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ct_q <= TEMP_OFF;
            cp_q <= PRESS_OFF;
            co_q <= BG_OFF;
            ch_q <= BG_OFF;
        end else begin
            ct_q <= lk.t;
            cp_q <= lk.p;
            co_q <= lk.o;
            ch_q <= lk.h;
        end
    end
    assign comp_temp = ct_q;
    assign comp_press = cp_q;
    assign comp_o2 = co_q;
    assign comp_rh = ch_q;

    // ****
    // Measurement filter
    // ****
    assign fdiff = $signed({2'h0, meas_raw}) - $signed({2'h0, filt_q});
    assign fstep = fdiff >>> fsh_q;
    assign fnew = $signed({2'h0, filt_q}) + fstep;
    assign filt_d = first_q ? fnew[15:0] : meas_raw;

    // Filtered value, first-sample flag, update pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_q <= 16'h0;
            first_q <= 1'b0;
            upd_q <= 1'b0;
        end else begin
            upd_q <= meas_stb;
            if (meas_stb) begin
                filt_q <= filt_d;
                first_q <= 1'b1;
            end
        end
    end
    assign dig_ppm = filt_q;
    assign dig_valid = first_q;

    // Startup watchdog: flags a late first measurement
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_cnt_q <= 32'h0;
            st_to_q <= 1'b0;
        end else if (!first_q && !st_to_q) begin
            st_cnt_q <= st_cnt_q + 32'h1;
            if (st_cnt_q == STARTUP_CYCLES - 32'h1) begin
                st_to_q <= 1'b1;
            end
        end
    end
    assign startup_done = first_q;
    assign startup_late = st_to_q;

    // ****
    // Analog output
    // ****
    assign lk.rng = rng;
    assign lk.meas = filt_q;
    assign lk.lo = lo_q;
    assign lk.hi = hi_q;
    assign lk.clip_pm = clip_q;
    assign lk.err_pm = err_q;

    aout_shaper u_shp (
        .s(lk.shp_m)
    );

    // Target state from limit compare
    always_comb begin
        tgt = lk.over_err ? AO_ERR : (lk.over_clip ? AO_CLIP : AO_NORM);
    end

    // Output state: error until first sample, stepwise return
    always_comb begin
        aout_state_d = aout_state_q;
        case (aout_state_q)
            AO_START: begin
                if (upd_q) begin
                    aout_state_d = tgt;
                end
            end
            AO_ERR: begin
                if (upd_q && tgt != AO_ERR) begin
                    aout_state_d = AO_CLIP;
                end
            end
            AO_CLIP, AO_NORM: begin
                if (upd_q) begin
                    aout_state_d = tgt;
                end
            end
            default: aout_state_d = AO_START;
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aout_state_q <= AO_START;
        end else begin
            aout_state_q <= aout_state_d;
        end
    end

    // Output level and error flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_q <= OUT_ZERO;
            err_q2 <= 1'b1;
        end else begin
            err_q2 <= (aout_state_q == AO_START) || (aout_state_q == AO_ERR);
            if ((aout_state_q == AO_START) || (aout_state_q == AO_ERR)) begin
                code_q <= errlvl_q;
            end else begin
                code_q <= lk.code;
            end
        end
    end
    assign aout_code = code_q;
    assign aout_err = err_q2;
    assign aout_en = ctrl_q[C_AMODE];

    // ****
    // Assertions
    // ****
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_err_held;
        aout_state_q == AO_ERR ##1 aout_state_q == AO_ERR;
    endsequence
    sequence s_pset_wr;
        wr_en && paddr == A_PSET && ctrl_q[C_PEN];
    endsequence

    a_temp_off:
        assert property (!ctrl_q[C_TEN] |=> comp_temp == TEMP_OFF) else $error("temp default wrong");
    a_temp_src:
        assert property (ctrl_q[C_TEN] && ctrl_q[C_TSRC] |=> comp_temp == $past(tsens_q))
            else $error("sensor temp not used");
    a_press_off:
        assert property (!ctrl_q[C_PEN] |=> comp_press == PRESS_OFF) else $error("pressure default wrong");
    a_bg_off:
        assert property (!ctrl_q[C_OEN] && !ctrl_q[C_HEN] |=> comp_o2 == BG_OFF && comp_rh == BG_OFF)
            else $error("gas default wrong");
    a_setpt_apply:
        assert property (s_pset_wr |-> ##2 comp_press == $past(pwdata[15:0], 2))
            else $error("pressure setpoint not applied");
    a_start_err:
        assert property (!first_q |-> aout_err) else $error("no error before first sample");
    a_err_level:
        assert property (s_err_held |-> aout_code == $past(errlvl_q)) else $error("error level not output");
    a_err_return:
        assert property ($past(aout_state_q) == AO_ERR && aout_state_q != AO_ERR |-> aout_state_q == AO_CLIP)
            else $error("skipped clipped step");
    a_volt_max:
        assert property (is_volt(rng) && $stable(ctrl_q) |-> aout_code <= VMAX && errlvl_q <= VMAX)
            else $error("voltage above maximum");
    a_dig_raw:
        assert property (meas_stb && !first_q |=> dig_ppm == $past(meas_raw)) else $error("digital value altered");
    a_range_lim:
        assert property (wr_en && paddr == A_CTRL && wr_rng != rng |=> clip_q == def_clip(rng) && err_q == PM_10)
            else $error("range limits not loaded");
    a_start_tmo:
        assert property (!first_q && !st_to_q && st_cnt_q == STARTUP_CYCLES - 32'h1 |=> startup_late)
            else $error("startup overrun not flagged");

endmodule : co2_comp_ctrl

/* verilog/comp_select.sv */
`timescale 1ns/100ps
module comp_select
    import co2_pkg::*;
(
    // Selection group
    co2_link_if.sel_m s
);
    // Neutral value when disabled, else sensor or setpoint
    assign s.t = !s.en[C_TEN] ? TEMP_OFF : (s.tsrc ? s.tsens : s.tset);
    assign s.p = !s.en[C_PEN] ? PRESS_OFF : s.pset;
    assign s.o = !s.en[C_OEN] ? BG_OFF : s.oset;
    assign s.h = !s.en[C_HEN] ? BG_OFF : s.hset;
endmodule : comp_select
